// File: hw/epb_bus_port.sv
// external memory and peripheral bus port of the motion core
`timescale 1ns/1ps
// Operation
// - low master reset pin from outside resets the whole chipset.
// - software reset drives master reset pin low briefly.
// - write strobe low while write data is driven on bus.
// - read strobe low while read data is taken from bus.
// - bus-valid low only while address and data are valid.
// - direction high for reads, low for writes.
// - second direction output always the complement of the first.
// - ready low stalls access one cycle, resample until high.
// - startup configuration reads wait while ready is held low.
// - peripheral select low when a peripheral is addressed.
// - memory select low when external memory is accessed.
// - reference clock at companion clock rate, idle during reset.
// - sixteen address lines; lines 0, 1, 15 reach companion chip.
// - other address lines serve DACs, word inputs, memory, user I/O.
// - one shared 16-bit bidirectional data bus for all transfers.
// - companion chip interrupt input is monitored by the device.
// - host interrupt output driven low to request host service.
module epb_bus_port #(
   parameter int ADDR_W = epb_pkg::ADDR_W,
   parameter int DATA_W = epb_pkg::DATA_W,
   parameter int SWRST_PULSE = epb_pkg::SWRST_CYCLES
)
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // core request side
   input wire logic reqValid,
   input wire epb_pkg::epb_req_t req,
   output logic reqReady,
   output logic rspValid,
   output logic [DATA_W-1:0] rspData,
   input wire logic startupCfgPending,
   input wire logic swResetReq,
   input wire logic hostIrqReq,
   output logic companionIrq,
   output logic chipReset,
   // external bus pins
   output logic [ADDR_W-1:0] busAddr,
   input wire logic [DATA_W-1:0] busDataIn,
   output logic [DATA_W-1:0] busDataOut,
   output logic busDataOe,
   output epb_pkg::epb_ctl_t busCtl,
   input wire logic ready,
   // misc pins
   input wire logic companion_irq_in,
   output logic host_irq_n,
   output logic reference_clock_output,
   input wire logic resetPinIn,
   output logic resetPinOut,
   output logic resetPinOe
);

   typedef enum logic [1:0]
   {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_DONE
   } epb_state_t;

   epb_state_t state_q, state_d;
   epb_pkg::epb_req_t cur_q, cur_d;
   epb_pkg::epb_ctl_t ctl_q, ctl_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] dOut_q, dOut_d;
   logic dOe_q, dOe_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic rspValid_q, rspValid_d;
   logic reqReady_q, reqReady_d;
   logic irqIn_q, irqIn_d;
   logic hostIrqN_q, hostIrqN_d;
   logic refClk_q, refClk_d;
   logic coreRst;
   logic rstOut, rstOe;

   // -------------------------------
   // reset pin handling
   // -------------------------------
   epb_reset_ctl #(
      .PULSE_CYCLES(SWRST_PULSE)
   ) u_reset (
      .clk(clk),
      .srst(srst),
      .resetPinIn(resetPinIn),
      .resetPinOut(rstOut),
      .resetPinOe(rstOe),
      .swResetReq(swResetReq),
      .chipReset(coreRst)
   );

   // -------------------------------
   // access sequencer next state
   // -------------------------------
   always_comb
   begin
      state_d = state_q;
      cur_d = cur_q;
      ctl_d = ctl_q;
      addr_d = addr_q;
      dOut_d = dOut_q;
      dOe_d = dOe_q;
      rdata_d = rdata_q;
      rspValid_d = 1'b0;
      reqReady_d = 1'b0;
      unique case (state_q)
         ST_IDLE:
         begin
            ctl_d = epb_pkg::CTL_IDLE;
            dOe_d = 1'b0;
            reqReady_d = ~(startupCfgPending && !ready);
            if (reqValid && reqReady_q)
            begin
               cur_d = req;
               reqReady_d = 1'b0;
               addr_d = req.addr;
               ctl_d.readNotWrite = req.read;
               ctl_d.writeNotRead = ~req.read;
               ctl_d.peripheralSelectN = ~(req.target == epb_pkg::EPB_TGT_PERIPH ||
                                           req.target == epb_pkg::EPB_TGT_COMPANION);
               ctl_d.memorySelectN = ~(req.target == epb_pkg::EPB_TGT_MEMORY);
               dOut_d = req.wdata;
               dOe_d = ~req.read;
               state_d = ST_SETUP;
            end
         end
         ST_SETUP:
         begin
            ctl_d.writeStrobeN = cur_q.read;
            ctl_d.readStrobeN = ~cur_q.read;
            ctl_d.busValidN = 1'b0;
            state_d = ST_STROBE;
         end
         ST_STROBE:
         begin
            if (ready)
            begin
               rdata_d = busDataIn;
               ctl_d = epb_pkg::CTL_IDLE;
               ctl_d.readNotWrite = cur_q.read;
               ctl_d.writeNotRead = ~cur_q.read;
               state_d = ST_DONE;
            end
         end
         ST_DONE:
         begin
            ctl_d = epb_pkg::CTL_IDLE;
            dOe_d = 1'b0;
            rspValid_d = 1'b1;
            state_d = ST_IDLE;
         end
      endcase
   end

   // -------------------------------
   // misc pins next state
   // -------------------------------
   always_comb
   begin
      irqIn_d = companion_irq_in;
      hostIrqN_d = ~hostIrqReq;
      refClk_d = ~refClk_q;
   end

   // -------------------------------
   // registers
   // -------------------------------
   always_ff @(posedge clk)
   begin
      if (srst || coreRst)
      begin
         state_q <= ST_IDLE;
         cur_q <= '0;
         ctl_q <= epb_pkg::CTL_IDLE;
         addr_q <= epb_pkg::ADDR_RST;
         dOut_q <= epb_pkg::DATA_RST;
         dOe_q <= 1'b0;
         rdata_q <= epb_pkg::DATA_RST;
         rspValid_q <= 1'b0;
         reqReady_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cur_q <= cur_d;
         ctl_q <= ctl_d;
         addr_q <= addr_d;
         dOut_q <= dOut_d;
         dOe_q <= dOe_d;
         rdata_q <= rdata_d;
         rspValid_q <= rspValid_d;
         reqReady_q <= reqReady_d;
      end
   end

   // -------------------------------
   // misc pin registers
   // -------------------------------
   always_ff @(posedge clk)
   begin
      if (srst || coreRst)
      begin
         irqIn_q <= 1'b0;
         hostIrqN_q <= 1'b1;
         refClk_q <= 1'b0;
      end
      else
      begin
         irqIn_q <= irqIn_d;
         hostIrqN_q <= hostIrqN_d;
         refClk_q <= refClk_d;
      end
   end

   // -------------------------------
   // outputs
   // -------------------------------
   assign reqReady = reqReady_q;
   assign rspValid = rspValid_q;
   assign rspData = rdata_q;
   assign companionIrq = irqIn_q;
   assign chipReset = coreRst;
   assign busAddr = addr_q;
   assign busDataOut = dOut_q;
   assign busDataOe = dOe_q;
   assign busCtl = ctl_q;
   assign host_irq_n = hostIrqN_q;
   assign reference_clock_output = refClk_q;
   assign resetPinOut = rstOut;
   assign resetPinOe = rstOe;

endmodule

// File: hw/epb_pkg.sv
// shared constants and carrier types for the external bus port
package epb_pkg;

   // widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;

   // companion chip address bits
   localparam int ADDR_BIT_LO = 0;
   localparam int ADDR_BIT_HI = 1;
   localparam int ADDR_BIT_TOP = 15;

   // timing
   localparam int CLK_HZ = 10_000_000;
   localparam int SWRST_TIME_NS = 1000;
   localparam int SWRST_CYCLES = (SWRST_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int RST_FILTER_CYCLES = 2;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;

   // reset values
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

   // kinds of external access
   typedef enum logic [1:0]
   {
      EPB_TGT_COMPANION,
      EPB_TGT_PERIPH,
      EPB_TGT_MEMORY
   } epb_target_t;

   // access request from the core
   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic read;
      epb_target_t target;
   } epb_req_t;

   // strobes and selects toward the pins
   typedef struct packed
   {
      logic writeStrobeN;
      logic readStrobeN;
      logic busValidN;
      logic readNotWrite;
      logic writeNotRead;
      logic peripheralSelectN;
      logic memorySelectN;
   } epb_ctl_t;

   localparam epb_ctl_t CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

endpackage

// File: hw/epb_reset_ctl.sv
// master reset pin handling: filter, software pulse and startup hold
`timescale 1ns/1ps
module epb_reset_ctl #(
   parameter int PULSE_CYCLES = epb_pkg::SWRST_CYCLES
)
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // pin side
   input wire logic resetPinIn,
   output logic resetPinOut,
   output logic resetPinOe,
   // core side
   input wire logic swResetReq,
   output logic chipReset
);

   logic [7:0] pulseCnt_q, pulseCnt_d;
   logic [1:0] pinLow_q, pinLow_d;
   logic chipReset_q, chipReset_d;
   logic pinOe_q, pinOe_d;

   // -------------------------------
   // next state
   // -------------------------------
   always_comb
   begin
      pulseCnt_d = pulseCnt_q;
      pinLow_d = {pinLow_q[0], ~resetPinIn};
      if (swResetReq && pulseCnt_q == epb_pkg::CNT_ZERO)
      begin
         pulseCnt_d = PULSE_CYCLES[7:0];
      end
      else if (pulseCnt_q != epb_pkg::CNT_ZERO)
      begin
         pulseCnt_d = pulseCnt_q - epb_pkg::CNT_ONE;
      end
      chipReset_d = (pinLow_q[1] && pinLow_q[0]) || (pulseCnt_q != epb_pkg::CNT_ZERO);
      pinOe_d = (pulseCnt_d != epb_pkg::CNT_ZERO);
   end

   // -------------------------------
   // registers
   // -------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pulseCnt_q <= epb_pkg::CNT_ZERO;
         pinLow_q <= 2'h0;
         chipReset_q <= 1'b1;
         pinOe_q <= 1'b0;
      end
      else
      begin
         pulseCnt_q <= pulseCnt_d;
         pinLow_q <= pinLow_d;
         chipReset_q <= chipReset_d;
         pinOe_q <= pinOe_d;
      end
   end

   assign resetPinOut = 1'b0;
   assign resetPinOe = pinOe_q;
   assign chipReset = chipReset_q;

endmodule

// File: verif/epb_bus_port_asserts.sv
// pin-level checker for the external bus port
`timescale 1ns/1ps
module epb_checker
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // watched ports
   input wire logic reqValid,
   input wire logic reqReady,
   input wire logic rspValid,
   input wire epb_pkg::epb_ctl_t busCtl,
   input wire logic busDataOe,
   input wire logic ready,
   input wire logic hostIrqReq,
   input wire logic host_irq_n,
   input wire logic reference_clock_output,
   input wire logic chipReset,
   input wire logic swResetReq,
   input wire logic resetPinOe
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ----
   // assertions
   // ----
   a_dir_inverse: assert property (busCtl.readNotWrite != busCtl.writeNotRead)
      else $error("direction pair not inverse");
   a_write_drive: assert property (!busCtl.writeStrobeN |-> busDataOe && !busCtl.readNotWrite)
      else $error("write strobe without drive");
   a_read_dir: assert property (!busCtl.readStrobeN |-> busCtl.readNotWrite && !busDataOe)
      else $error("read strobe with wrong direction");
   a_valid_strobe: assert property (!busCtl.busValidN |-> !(busCtl.writeStrobeN && busCtl.readStrobeN))
      else $error("bus valid outside a strobe");
   a_wait_stall: assert property (!busCtl.busValidN && !ready |=> !busCtl.busValidN)
      else $error("access ended while not ready");
   a_resp_order: assert property (rspValid |-> $past(busCtl.busValidN) && !$past(busCtl.busValidN, 2))
      else $error("response not after strobe end");
   a_take_busy: assert property (reqValid && reqReady |=> !reqReady [*4])
      else $error("request taken too soon");
   a_take_answer: assert property (reqValid && reqReady |-> ##[4:40] rspValid)
      else $error("no response in time");
   a_host_irq: assert property (hostIrqReq && !chipReset |=> !host_irq_n)
      else $error("host interrupt not driven");
   a_ref_toggle: assert property (!chipReset && !$past(chipReset) |->
      reference_clock_output != $past(reference_clock_output))
      else $error("reference clock stopped");
   a_sw_pin: assert property (swResetReq |-> ##[1:2] resetPinOe)
      else $error("reset pin not pulled");
   c_stall: cover property (!busCtl.busValidN && !ready);
   c_write: cover property (!busCtl.writeStrobeN);
   c_pin: cover property (resetPinOe);
endmodule

// File: verif/epb_partner.sv
// far-side model: wait states, read data, write capture
`timescale 1ns/1ps
module epb_partner
(
   // pins
   input wire logic clk,
   input wire epb_pkg::epb_ctl_t busCtl,
   input wire logic [15:0] busAddr,
   input wire logic [15:0] busDataOut,
   // control and capture
   input wire logic [1:0] waitLen,
   input wire logic holdOff,
   output logic ready,
   output logic [15:0] rdData,
   output logic [15:0] lastWr
);
   logic [1:0] w = 2'h0;
   logic [15:0] junk = 16'h1234;
   assign ready = !holdOff && (busCtl.busValidN || w == waitLen);
   assign rdData = busCtl.readStrobeN ? junk : ~busAddr;
   always @(posedge clk)
   begin
      junk <= junk + 16'h1357;
      w <= busCtl.busValidN ? 2'h0 : (w == waitLen ? w : w + 2'h1);
      if (!busCtl.writeStrobeN && ready)
         lastWr <= busDataOut;
   end
endmodule

// File: verif/epb_bus_port_test.sv
// self-checking bench for the external bus port
`timescale 1ns/1ps
module epb_bus_port_test;
   logic clk = 0;
   logic srst = 1;
   logic reqValid = 0;
   epb_pkg::epb_req_t req = '0;
   logic startupCfgPending = 0, swResetReq = 0, hostIrqReq = 0, companion_irq_in = 0, extRstN = 1, holdOff = 0;
   logic [1:0] waitLen = 2'h0;
   logic reqReady, rspValid, companionIrq, chipReset, busDataOe, ready, host_irq_n;
   logic reference_clock_output, resetPinOut, resetPinOe;
   logic [15:0] rspData, busAddr, busDataOut, rdData, lastWr;
   epb_pkg::epb_ctl_t busCtl, seen;
   logic [31:0] seed = 32'h0000_0003;
   logic [31:0] r;
   int miscompares = 0, n_tests = 0, cyc = 0, k;
   always #50 clk = ~clk;
   epb_bus_port #(.SWRST_PULSE(2)) i_epb_bus_port(.clk, .srst, .reqValid, .req, .reqReady, .rspValid,
      .rspData, .startupCfgPending, .swResetReq, .hostIrqReq, .companionIrq, .chipReset, .busAddr,
      .busDataIn(busDataOe ? busDataOut : rdData), .busDataOut, .busDataOe, .busCtl, .ready,
      .companion_irq_in, .host_irq_n, .reference_clock_output,
      .resetPinIn(resetPinOe ? resetPinOut : extRstN), .resetPinOut, .resetPinOe);
   epb_partner i_epb_partner(.clk, .busCtl, .busAddr, .busDataOut, .waitLen, .holdOff, .ready, .rdData, .lastWr);
   // ----
   // helpers
   // ----
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] expRd(logic [15:0] a);
      return ~a;
   endfunction
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic access(logic [15:0] a, logic [15:0] d, logic rd, epb_pkg::epb_target_t t);
      int n;
      @(posedge clk);
      reqValid <= 1;
      req <= '{a, d, rd, t};
      @(posedge clk);
      while (reqReady !== 1)
         @(posedge clk);
      reqValid <= 0;
      n = 0;
      seen = epb_pkg::CTL_IDLE;
      while (rspValid !== 1)
      begin
         @(posedge clk);
         n++;
         if (busCtl.busValidN === 0)
            seen = busCtl;
      end
      chk("latency", 16'(4 + waitLen), 16'(n));
      chk("memSel", t != epb_pkg::EPB_TGT_MEMORY, seen.memorySelectN);
      chk("perSel", t == epb_pkg::EPB_TGT_MEMORY, seen.peripheralSelectN);
      chk("dir", rd, seen.readNotWrite);
      if (rd)
         chk("rdata", expRd(a), rspData);
      else
         chk("wdata", d, lastWr);
      chk("hostIrq", !hostIrqReq, host_irq_n);
      chk("compIrq", companion_irq_in, companionIrq);
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         miscompares++;
         conclude();
      end
   end
   // ----
   // sequence
   // ----
   initial
   begin
      repeat (5) @(posedge clk);
      chk("refClk", 0, reference_clock_output);
      chk("chipRst", 1, chipReset);
      srst <= 0;
      startupCfgPending <= 1;
      holdOff <= 1;
      fork
         access(16'h0003, 16'h0000, 1, epb_pkg::EPB_TGT_COMPANION);
         begin
            repeat (12) @(posedge clk);
            chk("held", 0, reqReady);
            holdOff <= 0;
         end
      join
      startupCfgPending <= 0;
      waitLen <= 2'h3;
      access(16'hFFFF, 16'h0000, 0, epb_pkg::EPB_TGT_MEMORY);
      for (int i = 0; i < 40; i++)
      begin
         r = rnd();
         waitLen <= r[1:0];
         hostIrqReq <= r[2];
         companion_irq_in <= r[3];
         access(r[31:16], r[15:0], r[4], epb_pkg::epb_target_t'(r[6:5] % 2'd3));
      end
      swResetReq <= 1;
      @(posedge clk);
      swResetReq <= 0;
      k = 0;
      repeat (6)
      begin
         @(posedge clk);
         k += resetPinOe;
         if (resetPinOe)
            chk("pinDrive", 16'h0000, 16'(resetPinOut));
      end
      chk("pinPulse", 16'h0002, 16'(k));
      extRstN <= 0;
      repeat (4) @(posedge clk);
      extRstN <= 1;
      chk("pinRst", 1, chipReset);
      access(16'h8001, 16'h5A5A, 0, epb_pkg::EPB_TGT_PERIPH);
      conclude();
   end
endmodule
bind epb_bus_port epb_checker i_epb_checker(.clk, .srst, .reqValid, .reqReady, .rspValid, .busCtl, .busDataOe,
   .ready, .hostIrqReq, .host_irq_n, .reference_clock_output, .chipReset, .swResetReq, .resetPinOe);
